// File: inc/faf_consts.vh
// faf_consts.vh: register offsets, field positions and reset values
// of the identifier acceptance filter; definitions only.
`ifndef FAF_CONSTS_VH
`define FAF_CONSTS_VH

`define FAF_ADDR_W 16
`define FAF_OFF_DIAG_CTRL 16'hf804
`define FAF_OFF_MASK_A_UP 16'hf805
`define FAF_OFF_MASK_A_LO 16'hf806
`define FAF_OFF_CODE1_UP 16'hf807
`define FAF_OFF_CODE1_LO 16'hf808
`define FAF_OFF_MASK_B_UP 16'hf809
`define FAF_OFF_MASK_B_LO 16'hf80a
`define FAF_OFF_CODE2_UP 16'hf80b
`define FAF_OFF_CODE2_LO 16'hf80c
`define FAF_OFF_CODE3_UP 16'hf80d
`define FAF_OFF_CODE3_LO 16'hf80e
`define FAF_OFF_CODE4_UP 16'hf80f
`define FAF_OFF_CODE4_LO 16'hf810
`define FAF_OFF_CONF 16'hf803

`define FAF_RST_FILTER 8'h00
`define FAF_RST_DIAG_CTRL 8'h17
`define FAF_RST_CONF 8'h08
// lower register: bits 7..3 used, 2..0 read zero
`define FAF_LO_USED 8'hf8

// diagnosis control fields
`define FAF_BIT_PULSE 3
`define FAF_BIT_TXOFF 2
`define FAF_BIT_SEL_HI 1
`define FAF_BIT_SEL_LO 0
// configuration mask enable fields
`define FAF_BIT_MEN_HI 1
`define FAF_BIT_MEN_LO 0

// line selection codes
`define FAF_LINE_DIFF 2'b00
`define FAF_LINE_A 2'b01
`define FAF_LINE_B 2'b10
`define FAF_LINE_AUTO 2'b11

`endif

// File: design/faf_filter.v
// faf_filter.v: identifier acceptance filter and line diagnosis control.
// assumes a byte-wide cpu port with bit or byte writes on sys_clk and a
// receiver that presents identifier bytes and a frame end strobe on sys_clk.
//
// Functional notes
// - Writing 1 to the pulse request bit emits one diagnosis sync tick, writing 0 does not.
// - Transmit line checking runs while its control bit is 0 and is suppressed while it is 1.
// - The line select field picks differential, single a, single b or automatic line.
// - A mask bit of 0 makes its position compared, a mask bit of 1 makes it always match.
// - Each pair holds id bits 11..4 upper, bits 3..0 and ext in lower 7..3, lower 2..0 read zero.
// - Code one is compared under mask a.
// - Codes two, three and four are compared under mask b.
// - Reset clears all mask and code registers to zero.
// - Bit writes and byte writes are both accepted, a bit write touching one bit only.
// - The masked comparison decides whether the receive byte interrupt is raised.
// - The receive byte interrupt is raised only when some code matches under its mask or the mask enable field inhibits that code's mask.
// - A first byte match with a second byte miss gives one interrupt then silence to frame end.
// - The mask enable field applies both masks, inhibits mask a, mask b, or both.
`timescale 1ns/1ps
`include "faf_consts.vh"

module faf_filter (
    // clock and reset
    input wire sys_clk,
    input wire sys_rst,
    // cpu register port
    input wire [15:0] cpu_addr,
    input wire cpu_wr,
    input wire cpu_bit_wr,
    input wire [2:0] cpu_bit_sel,
    input wire [7:0] cpu_wdata,
    input wire cpu_rd,
    output reg [7:0] cpu_rdata,
    // receiver path
    input wire rx_byte_valid,
    input wire [7:0] rx_byte,
    input wire message_end_flag,
    input wire rx_differential_line,
    input wire rx_single_line_a,
    input wire rx_single_line_b,
    input wire auto_line_data,
    // outputs
    output reg receive_byte_irq,
    output reg diagnosis_sync_tick,
    output reg tx_line_check_en,
    output reg [1:0] line_mode,
    output reg rx_line_data
);
    localparam ST_ID1 = 2'd0;
    localparam ST_ID2 = 2'd1;
    localparam ST_DATA = 2'd2;
    localparam ST_MUTE = 2'd3;
    reg [7:0] diag_q;
    reg [7:0] conf_q;
    reg [7:0] mask_a_upper_q;
    reg [7:0] mask_a_lower_q;
    reg [7:0] code1_up_q;
    reg [7:0] code1_lo_q;
    reg [7:0] mask_b_upper_q;
    reg [7:0] mask_b_lower_q;
    reg [7:0] code2_up_q;
    reg [7:0] code2_lo_q;
    reg [7:0] code3_up_q;
    reg [7:0] code3_lo_q;
    reg [7:0] code4_up_q;
    reg [7:0] code4_lo_q;
    reg [1:0] state_q;
    reg [3:0] hit_up_q;
    reg [2:0] line_s1_q;
    reg [2:0] line_s2_q;
    reg [2:0] line_s3_q;
    reg [2:0] line_st_q;
    reg [7:0] rdata_d;
    reg [3:0] hit_d;
    // new register value after a byte or single-bit write
    function [7:0] faf_wr;
        input [7:0] old;
        input bit_mode;
        input [2:0] sel;
        input [7:0] data;
        reg [7:0] tmp;
        begin
            tmp = old;
            if (bit_mode) begin
                tmp[sel] = data[0];
            end else begin
                tmp = data;
            end
            faf_wr = tmp;
        end
    endfunction
    // masked compare of one byte
    function faf_cmp;
        input [7:0] rx;
        input [7:0] code;
        input [7:0] mask;
        input mask_off;
        begin
            faf_cmp = mask_off | (&(mask | ~(rx ^ code)));
        end
    endfunction
    wire wr_any = cpu_wr | cpu_bit_wr;
    wire men_a_off = conf_q[`FAF_BIT_MEN_LO];
    wire men_b_off = conf_q[`FAF_BIT_MEN_HI];
    // register writes
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            diag_q <= `FAF_RST_DIAG_CTRL;
            conf_q <= `FAF_RST_CONF;
            mask_a_upper_q <= `FAF_RST_FILTER;
            mask_a_lower_q <= `FAF_RST_FILTER;
            code1_up_q <= `FAF_RST_FILTER;
            code1_lo_q <= `FAF_RST_FILTER;
            mask_b_upper_q <= `FAF_RST_FILTER;
            mask_b_lower_q <= `FAF_RST_FILTER;
            code2_up_q <= `FAF_RST_FILTER;
            code2_lo_q <= `FAF_RST_FILTER;
            code3_up_q <= `FAF_RST_FILTER;
            code3_lo_q <= `FAF_RST_FILTER;
            code4_up_q <= `FAF_RST_FILTER;
            code4_lo_q <= `FAF_RST_FILTER;
        end else if (wr_any) begin
            if (cpu_addr == `FAF_OFF_DIAG_CTRL) begin
                diag_q <= faf_wr(diag_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_CONF) begin
                conf_q <= faf_wr(conf_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_MASK_A_UP) begin
                mask_a_upper_q <= faf_wr(mask_a_upper_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_MASK_A_LO) begin
                mask_a_lower_q <= faf_wr(mask_a_lower_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata)
                    & `FAF_LO_USED;
            end else if (cpu_addr == `FAF_OFF_CODE1_UP) begin
                code1_up_q <= faf_wr(code1_up_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_CODE1_LO) begin
                code1_lo_q <= faf_wr(code1_lo_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata)
                    & `FAF_LO_USED;
            end else if (cpu_addr == `FAF_OFF_MASK_B_UP) begin
                mask_b_upper_q <= faf_wr(mask_b_upper_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_MASK_B_LO) begin
                mask_b_lower_q <= faf_wr(mask_b_lower_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata)
                    & `FAF_LO_USED;
            end else if (cpu_addr == `FAF_OFF_CODE2_UP) begin
                code2_up_q <= faf_wr(code2_up_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_CODE2_LO) begin
                code2_lo_q <= faf_wr(code2_lo_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata)
                    & `FAF_LO_USED;
            end else if (cpu_addr == `FAF_OFF_CODE3_UP) begin
                code3_up_q <= faf_wr(code3_up_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_CODE3_LO) begin
                code3_lo_q <= faf_wr(code3_lo_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata)
                    & `FAF_LO_USED;
            end else if (cpu_addr == `FAF_OFF_CODE4_UP) begin
                code4_up_q <= faf_wr(code4_up_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata);
            end else if (cpu_addr == `FAF_OFF_CODE4_LO) begin
                code4_lo_q <= faf_wr(code4_lo_q, cpu_bit_wr, cpu_bit_sel, cpu_wdata)
                    & `FAF_LO_USED;
            end
        end else begin
            // pulse request bit self-clears on the same edge that raises its tick
            diag_q[`FAF_BIT_PULSE] <= 1'b0;
        end
    end
    // read mux; the pulse bit reads back until its tick is issued
    always @* begin
        rdata_d = 8'h00;
        if (cpu_addr == `FAF_OFF_DIAG_CTRL) begin
            rdata_d = diag_q;
        end else if (cpu_addr == `FAF_OFF_CONF) begin
            rdata_d = conf_q;
        end else if (cpu_addr == `FAF_OFF_MASK_A_UP) begin
            rdata_d = mask_a_upper_q;
        end else if (cpu_addr == `FAF_OFF_MASK_A_LO) begin
            rdata_d = mask_a_lower_q;
        end else if (cpu_addr == `FAF_OFF_CODE1_UP) begin
            rdata_d = code1_up_q;
        end else if (cpu_addr == `FAF_OFF_CODE1_LO) begin
            rdata_d = code1_lo_q;
        end else if (cpu_addr == `FAF_OFF_MASK_B_UP) begin
            rdata_d = mask_b_upper_q;
        end else if (cpu_addr == `FAF_OFF_MASK_B_LO) begin
            rdata_d = mask_b_lower_q;
        end else if (cpu_addr == `FAF_OFF_CODE2_UP) begin
            rdata_d = code2_up_q;
        end else if (cpu_addr == `FAF_OFF_CODE2_LO) begin
            rdata_d = code2_lo_q;
        end else if (cpu_addr == `FAF_OFF_CODE3_UP) begin
            rdata_d = code3_up_q;
        end else if (cpu_addr == `FAF_OFF_CODE3_LO) begin
            rdata_d = code3_lo_q;
        end else if (cpu_addr == `FAF_OFF_CODE4_UP) begin
            rdata_d = code4_up_q;
        end else if (cpu_addr == `FAF_OFF_CODE4_LO) begin
            rdata_d = code4_lo_q;
        end
    end
    // per-code hit for the current byte, lower byte only bits 7..3 count
    always @* begin
        hit_d = 4'h0;
        if (state_q == ST_ID1) begin
            hit_d[0] = faf_cmp(rx_byte, code1_up_q, mask_a_upper_q, men_a_off);
            hit_d[1] = faf_cmp(rx_byte, code2_up_q, mask_b_upper_q, men_b_off);
            hit_d[2] = faf_cmp(rx_byte, code3_up_q, mask_b_upper_q, men_b_off);
            hit_d[3] = faf_cmp(rx_byte, code4_up_q, mask_b_upper_q, men_b_off);
        end else begin
            // masked equality, mask 1 is don't care
            hit_d[0] = faf_cmp(rx_byte, code1_lo_q, mask_a_lower_q | ~`FAF_LO_USED, men_a_off);
            hit_d[1] = faf_cmp(rx_byte, code2_lo_q, mask_b_lower_q | ~`FAF_LO_USED, men_b_off);
            hit_d[2] = faf_cmp(rx_byte, code3_lo_q, mask_b_lower_q | ~`FAF_LO_USED, men_b_off);
            hit_d[3] = faf_cmp(rx_byte, code4_lo_q, mask_b_lower_q | ~`FAF_LO_USED, men_b_off);
        end
    end
    // frame sequencer and receive interrupt
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            state_q <= ST_ID1;
            hit_up_q <= 4'h0;
            receive_byte_irq <= 1'b0;
        end else begin
            receive_byte_irq <= 1'b0;
            if (message_end_flag) begin
                state_q <= ST_ID1;
                hit_up_q <= 4'h0;
            end else if (rx_byte_valid) begin
                case (state_q)
                    ST_ID1: begin
                        hit_up_q <= hit_d;
                        receive_byte_irq <= |hit_d;
                        state_q <= (|hit_d) ? ST_ID2 : ST_MUTE;
                    end
                    ST_ID2: begin
                        // second byte miss silences the frame
                        receive_byte_irq <= |(hit_up_q & hit_d);
                        state_q <= (|(hit_up_q & hit_d)) ? ST_DATA : ST_MUTE;
                    end
                    ST_DATA: begin
                        receive_byte_irq <= 1'b1;
                    end
                    default: begin
                        state_q <= ST_MUTE;
                    end
                endcase
            end
        end
    end
    // three-stage line synchronisers
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            line_s1_q <= 3'b111;
            line_s2_q <= 3'b111;
            line_s3_q <= 3'b111;
            line_st_q <= 3'b111;
        end else begin
            line_s1_q <= {rx_single_line_b, rx_single_line_a, rx_differential_line};
            line_s2_q <= line_s1_q;
            line_s3_q <= line_s2_q;
            line_st_q <= (line_s2_q & line_s3_q) | (line_st_q & (line_s2_q | line_s3_q));
        end
    end
    // diagnosis controls and line choice
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            diagnosis_sync_tick <= 1'b0;
            tx_line_check_en <= 1'b0;
            line_mode <= `FAF_LINE_AUTO;
            rx_line_data <= 1'b1;
            cpu_rdata <= 8'h00;
        end else begin
            diagnosis_sync_tick <= diag_q[`FAF_BIT_PULSE] & ~wr_any;
            // check on while bit is 0
            tx_line_check_en <= ~diag_q[`FAF_BIT_TXOFF];
            line_mode <= {diag_q[`FAF_BIT_SEL_HI], diag_q[`FAF_BIT_SEL_LO]};
            case ({diag_q[`FAF_BIT_SEL_HI], diag_q[`FAF_BIT_SEL_LO]})
                `FAF_LINE_DIFF: rx_line_data <= line_st_q[0];
                `FAF_LINE_A: rx_line_data <= line_st_q[1];
                `FAF_LINE_B: rx_line_data <= line_st_q[2];
                default: rx_line_data <= auto_line_data;
            endcase
            cpu_rdata <= cpu_rd ? rdata_d : 8'h00;
        end
    end

endmodule

// File: verif/faf_filter_monitor.sv
// faf_filter_monitor.sv: port assertions for the acceptance filter.
// assumes a bind onto faf_filter, every signal sampled on sys_clk.
`timescale 1ns/1ps
`include "faf_consts.vh"
module faf_filter_monitor (
    // clock, reset and cpu port
    input wire sys_clk,
    input wire sys_rst,
    input wire [15:0] cpu_addr,
    input wire cpu_wr,
    input wire cpu_bit_wr,
    input wire [7:0] cpu_wdata,
    input wire cpu_rd,
    input wire [7:0] cpu_rdata,
    // receiver path and outputs
    input wire rx_byte_valid,
    input wire message_end_flag,
    input wire rx_differential_line,
    input wire auto_line_data,
    input wire receive_byte_irq,
    input wire diagnosis_sync_tick,
    input wire tx_line_check_en,
    input wire [1:0] line_mode,
    input wire rx_line_data
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // write and read decodes
    wire diag_any = (cpu_wr || cpu_bit_wr) && cpu_addr == `FAF_OFF_DIAG_CTRL;
    wire diag_byte = diag_any && !cpu_bit_wr;
    wire low_reg = cpu_addr >= `FAF_OFF_MASK_A_LO && cpu_addr <= `FAF_OFF_CODE4_LO
        && !cpu_addr[0];
    // diagnosis tick; any register write in the next cycle holds the tick back
    a_tick_after_write: assert property (diag_byte && cpu_wdata[`FAF_BIT_PULSE]
        ##1 !(cpu_wr || cpu_bit_wr) |=> diagnosis_sync_tick)
        else $error("no tick after pulse request");
    a_tick_single: assert property (diagnosis_sync_tick |=> !diagnosis_sync_tick)
        else $error("tick longer than one cycle");
    // diagnosis field outputs
    a_mode_field: assert property (diag_byte ##1 (!diag_any)[*2]
        |-> line_mode == $past(cpu_wdata[1:0], 2)) else $error("line mode not written");
    a_tx_polarity: assert property (diag_byte ##1 (!diag_any)[*2]
        |-> tx_line_check_en == !$past(cpu_wdata[`FAF_BIT_TXOFF], 2))
        else $error("tx check level wrong");
    // receive line selection
    a_line_forced: assert property (
        (line_mode == `FAF_LINE_DIFF && $stable(rx_differential_line))[*8]
        |-> rx_line_data == rx_differential_line) else $error("forced line not followed");
    a_line_auto: assert property ((line_mode == `FAF_LINE_AUTO)[*2]
        |-> rx_line_data == $past(auto_line_data)) else $error("auto line not followed");
    // receive interrupt and read data
    a_irq_cause: assert property (receive_byte_irq |-> $past(rx_byte_valid))
        else $error("irq without a received byte");
    a_end_silence: assert property (message_end_flag |=> !receive_byte_irq)
        else $error("irq after frame end");
    a_low_bits_zero: assert property (cpu_rd && low_reg |=> cpu_rdata[2:0] == 3'b000)
        else $error("lower register bits not zero");
    // main scenarios reached
    c_tick: cover property (diagnosis_sync_tick);
    c_irq_run: cover property (receive_byte_irq ##1 receive_byte_irq);
    c_frame_end: cover property (message_end_flag);
endmodule

// File: verif/faf_rx_model.sv
// faf_rx_model.sv: receiver path model, identifier bytes and line levels.
// assumes the bench calls its tasks; all changes land on the falling edge.
`timescale 1ns/1ps
module faf_rx_model (
    // clock
    input wire sys_clk,
    // byte path
    output logic rx_byte_valid,
    output logic [7:0] rx_byte,
    output logic message_end_flag,
    // line levels
    output logic rx_differential_line,
    output logic rx_single_line_a,
    output logic rx_single_line_b,
    output logic auto_line_data
);
    // idle receiver, lines recessive
    initial begin
        rx_byte_valid = 1'b0;
        rx_byte = 8'h00;
        message_end_flag = 1'b0;
        {rx_differential_line, rx_single_line_a, rx_single_line_b, auto_line_data} = 4'hf;
    end
    // two id bytes, two data bytes, frame end; gap 0 keeps valid up
    task automatic send_frame(input logic [7:0] b1, input logic [7:0] b2, input int gap);
        logic [7:0] fr [4];
        fr = '{b1, b2, 8'h5a, 8'ha5};
        for (int i = 0; i < 4; i++) begin
            @(negedge sys_clk);
            rx_byte_valid = 1'b1;
            rx_byte = fr[i];
            if (gap > 0) begin
                @(negedge sys_clk);
                rx_byte_valid = 1'b0;
                rx_byte = ~fr[i]; // stale byte never lingers
                repeat (gap - 1) @(negedge sys_clk);
            end
        end
        @(negedge sys_clk);
        rx_byte_valid = 1'b0;
        rx_byte = ~rx_byte;
        message_end_flag = 1'b1;
        @(negedge sys_clk);
        message_end_flag = 1'b0;
    endtask
    // line levels in order differential, a, b, auto
    task automatic set_lines(input logic [3:0] lv);
        {rx_differential_line, rx_single_line_a, rx_single_line_b, auto_line_data} = lv;
    endtask
endmodule

// File: verif/faf_filter_tb.sv
// faf_filter_tb.sv: self-checking bench for the acceptance filter.
// assumes faf_filter, faf_rx_model and faf_filter_monitor are compiled.
`timescale 1ns/1ps
`include "faf_consts.vh"
module faf_filter_tb;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic cpu_wr = 1'b0;
    logic cpu_bit_wr = 1'b0;
    logic [2:0] cpu_bit_sel = 3'h0;
    logic [7:0] cpu_wdata = 8'h00;
    logic cpu_rd = 1'b0;
    wire [7:0] cpu_rdata;
    wire [7:0] rx_byte;
    wire [1:0] line_mode;
    wire rx_byte_valid, message_end_flag, rx_differential_line, rx_single_line_a;
    wire rx_single_line_b, auto_line_data, receive_byte_irq, diagnosis_sync_tick;
    wire tx_line_check_en, rx_line_data;
    int fails = 0;
    int n_checks = 0;
    int n_irq = 0;
    int n_tick = 0;
    // clock and event counters
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (receive_byte_irq === 1'b1) n_irq <= n_irq + 1;
        if (diagnosis_sync_tick === 1'b1) n_tick <= n_tick + 1;
    end
    faf_filter faf_filter_inst (.sys_clk, .sys_rst, .cpu_addr, .cpu_wr, .cpu_bit_wr,
        .cpu_bit_sel, .cpu_wdata, .cpu_rd, .cpu_rdata, .rx_byte_valid, .rx_byte,
        .message_end_flag, .rx_differential_line, .rx_single_line_a, .rx_single_line_b,
        .auto_line_data, .receive_byte_irq, .diagnosis_sync_tick, .tx_line_check_en,
        .line_mode, .rx_line_data);
    faf_rx_model faf_rx_model_inst (.sys_clk, .rx_byte_valid, .rx_byte, .message_end_flag,
        .rx_differential_line, .rx_single_line_a, .rx_single_line_b, .auto_line_data);
    // compare and bus tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic bit_mode = 0);
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_bit_sel = d[6:4];
        cpu_wr = !bit_mode;
        cpu_bit_wr = bit_mode;
        @(negedge sys_clk);
        cpu_wr = 1'b0;
        cpu_bit_wr = 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge sys_clk);
        cpu_rd = 1'b0;
        chk(cpu_rdata, exp);
    endtask
    task automatic frame(input logic [7:0] b1, b2, input int exp, input int gap);
        int t0;
        t0 = n_irq;
        faf_rx_model_inst.send_frame(b1, b2, gap);
        repeat (2) @(negedge sys_clk);
        chk(8'(n_irq - t0), 8'(exp));
    endtask
    // reset values, byte and bit writes
    task automatic test_regs();
        for (int i = 0; i < 12; i++) rd(16'hf805 + 16'(i), 8'h00);
        rd(`FAF_OFF_DIAG_CTRL, `FAF_RST_DIAG_CTRL);
        rd(`FAF_OFF_CONF, `FAF_RST_CONF);
        rd(16'hf820, 8'h00);
        for (int i = 0; i < 12; i++) begin
            wr(16'hf805 + 16'(i), 8'hff);
            rd(16'hf805 + 16'(i), i[0] ? 8'hf8 : 8'hff);
        end
        wr(`FAF_OFF_MASK_A_UP, 8'h20, 1'b1);
        rd(`FAF_OFF_MASK_A_UP, 8'hfb);
    endtask
    // reset in mid-run clears the filled registers again
    task automatic test_reset();
        @(negedge sys_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        for (int i = 0; i < 12; i++) rd(16'hf805 + 16'(i), 8'h00);
        chk({6'h00, line_mode}, {6'h00, `FAF_LINE_AUTO});
        chk({7'h00, tx_line_check_en}, 8'h00);
    endtask
    // line select, transmit check and tick
    task automatic test_diag();
        int t0;
        for (int m = 0; m < 4; m++) begin
            wr(`FAF_OFF_DIAG_CTRL, {5'h00, m[0], m[1:0]});
            faf_rx_model_inst.set_lines(~(4'b1000 >> m));
            repeat (8) @(negedge sys_clk);
            chk({7'h00, rx_line_data}, 8'h00);
            chk({6'h00, line_mode}, 8'(m));
            chk({7'h00, tx_line_check_en}, {7'h00, ~m[0]});
            faf_rx_model_inst.set_lines(4'b1000 >> m);
            repeat (8) @(negedge sys_clk);
            chk({7'h00, rx_line_data}, 8'h01);
        end
        t0 = n_tick;
        wr(`FAF_OFF_DIAG_CTRL, 8'h0b);
        repeat (4) @(negedge sys_clk);
        chk(8'(n_tick - t0), 8'h01);
        wr(`FAF_OFF_DIAG_CTRL, 8'h03);
        repeat (4) @(negedge sys_clk);
        chk(8'(n_tick - t0), 8'h01);
    endtask
    task automatic test_filter();
        logic [7:0] cfg [12] = '{8'h00, 8'h00, 8'ha5, 8'hc8, 8'h00, 8'h00, 8'h12, 8'h30,
            8'h3c, 8'h38, 8'hff, 8'h08};
        for (int i = 0; i < 12; i++) wr(16'hf805 + 16'(i), cfg[i]);
        frame(8'ha5, 8'hc8, 4, 2);
        frame(8'ha5, 8'hc0, 1, 1);
        frame(8'h12, 8'h30, 4, 1);
        frame(8'ha5, 8'h30, 1, 1);
        frame(8'hff, 8'hf8, 1, 1);
        frame(8'h77, 8'h00, 0, 1);
        frame(8'h3c, 8'h38, 4, 0);
        wr(`FAF_OFF_MASK_A_LO, 8'h31, 1'b1);
        frame(8'ha5, 8'hc0, 4, 1);
        for (int k = 0; k < 4; k++) begin
            wr(`FAF_OFF_CONF, 8'h08 | 8'(k));
            frame(8'h77, 8'h00, (k > 0) ? 4 : 0, 1);
        end
    endtask
    // verdict and end of run
    task automatic summarize();
        $display("checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (6) @(negedge sys_clk);
        sys_rst = 1'b0;
        test_regs();
        test_reset();
        test_diag();
        test_filter();
        summarize();
    end
    // watchdog well beyond the expected run
    initial begin
        #100000;
        fails++;
        summarize();
    end
endmodule
bind faf_filter faf_filter_monitor faf_filter_monitor_inst (.sys_clk, .sys_rst, .cpu_addr,
    .cpu_wr, .cpu_bit_wr, .cpu_wdata, .cpu_rd, .cpu_rdata, .rx_byte_valid, .message_end_flag,
    .rx_differential_line, .auto_line_data, .receive_byte_irq, .diagnosis_sync_tick,
    .tx_line_check_en, .line_mode, .rx_line_data);
